// ### verilog/reset_wake_strap_control.sv
/*
  Reset, power-on reset, strap latch, write gate and wake control.
  Assumes rst_n is the chip power-on reset net and all pins are asynchronous.
*/
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module reset_wake_strap_control
(
  // Clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Pins
  input  wire logic        external_reset_low_input,
  input  wire logic        chip_select_low,
  input  wire logic        write_strobe_low,
  input  wire logic        wake_event,
  input  wire logic        crossover_auto_strap,
  input  wire logic        speed_strap,
  // Wake indicator pin
  output logic             wake_indicator_out,
  output logic             wake_indicator_oe,
  // Link defaults, sleep mode and core reset
  output logic             link_speed_100,
  output logic             link_full_duplex,
  output logic             link_autoneg_en,
  output logic             crossover_auto_en,
  output logic             sleep_mode,
  output logic             core_reset_n,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             irq
);
  typedef enum logic [1:0]
  {
    ST_HOLD  = 2'b00,
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } mode_e;

  logic       ext_rst_s;
  logic       cs_s;
  logic       wr_s;
  logic       wake_s;
  logic       xover_s;
  logic       speed_s;
  logic [4:0] por_cnt;
  logic       sys_rst;
  logic       sys_rst_d;
  logic       speed_latched;
  logic       xover_latched;
  logic       no_read;
  mode_e      mode;
  logic [4:0] ctrl;
  logic [rwsc_pkg::EV_W-1:0] ev_status;
  logic [rwsc_pkg::EV_W-1:0] ev_mask;
  logic       wake_pending;
  logic       host_wr_pin;
  logic       host_wr_pin_d;
  logic       wake_write;
  logic       req;
  logic       rd_req;
  logic       wr_req;
  logic       wr_ok;
  logic [rwsc_pkg::EV_W-1:0] ev_set;
  logic [31:0] status_word;
  logic [31:0] next_dat;

  // Pins pass two flops before use
  rwsc_sync u_sync_rst (.clock(clock), .rst_n(rst_n),
    .d(!external_reset_low_input), .q(ext_rst_s));
  rwsc_sync u_sync_cs (.clock(clock), .rst_n(rst_n),
    .d(!chip_select_low), .q(cs_s));
  rwsc_sync u_sync_wr (.clock(clock), .rst_n(rst_n),
    .d(!write_strobe_low), .q(wr_s));
  rwsc_sync u_sync_wake (.clock(clock), .rst_n(rst_n),
    .d(wake_event), .q(wake_s));
  rwsc_sync u_sync_xo (.clock(clock), .rst_n(rst_n),
    .d(crossover_auto_strap), .q(xover_s));
  rwsc_sync u_sync_sp (.clock(clock), .rst_n(rst_n),
    .d(speed_strap), .q(speed_s));

  // Internal power-on stretch keeps logic reset with no external reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      por_cnt <= 5'h00;
    else if (por_cnt != 5'(rwsc_pkg::POR_CYCLES))
      por_cnt <= por_cnt + 5'h01;
  end

  // Combined reset, synchronous to clock
  assign sys_rst = ext_rst_s || (por_cnt != 5'(rwsc_pkg::POR_CYCLES));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sys_rst_d <= 1'b1;
    else
      sys_rst_d <= sys_rst;
  end

  // Straps caught on the release edge only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_latched <= 1'b0;
      xover_latched <= 1'b0;
    end
    else if (sys_rst_d && !sys_rst)
    begin
      speed_latched <= speed_s;
      xover_latched <= xover_s;
    end
  end

  // Defaults from the latched speed and crossover straps
  assign link_speed_100    = speed_latched;
  assign link_full_duplex  = 1'b0;
  assign link_autoneg_en   = speed_latched;
  assign crossover_auto_en = xover_latched;
  assign core_reset_n      = !sys_rst;

  // Pin write cycle: chip select with write strobe, rising edge
  assign host_wr_pin = cs_s && wr_s;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      host_wr_pin_d <= 1'b0;
    else
      host_wr_pin_d <= host_wr_pin;
  end

  // Any write cycle wakes, whatever its address or data
  assign wake_write = (host_wr_pin && !host_wr_pin_d) || wr_req;

  // Register bus decode; classic single cycle, ack one cycle later
  assign req    = cyc_i && stb_i && !ack_o;
  assign rd_req = req && !we_i;
  assign wr_req = req && we_i;
  // Writes are dropped while no read has happened
  assign wr_ok  = wr_req && !no_read && mode == ST_RUN;

  // Power mode; wake events never resume, only a host write does
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode <= ST_HOLD;
    else if (sys_rst)
      mode <= ST_HOLD;
    else
    begin
      unique case (mode)
        ST_HOLD:
          mode <= ST_RUN;
        ST_RUN:
          if (wr_ok && adr_i == rwsc_pkg::OFS_CTRL && sel_i[0]
              && dat_i[rwsc_pkg::CTRL_SLEEP])
            mode <= ST_SLEEP;
        ST_SLEEP:
          if (wake_write)
            mode <= ST_RUN;
        default:
          mode <= ST_HOLD;
      endcase
    end
  end

  assign sleep_mode = (mode == ST_SLEEP);

  // First-read flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      no_read <= 1'b1;
    else if (sys_rst || mode == ST_HOLD)
      no_read <= 1'b1;
    else if (mode == ST_SLEEP && wake_write)
      no_read <= 1'b1;
    else if (rd_req && mode == ST_RUN)
      no_read <= 1'b0;
  end

  // Control register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= rwsc_pkg::CTRL_RESET[4:0];
    else if (sys_rst)
      ctrl <= rwsc_pkg::CTRL_RESET[4:0];
    else if (wr_ok && adr_i == rwsc_pkg::OFS_CTRL && sel_i[0])
      ctrl <= {1'b0, 1'b0, dat_i[2:0]};
  end

  // Wake latch: set wins over the software clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wake_pending <= 1'b0;
    else if (sys_rst)
      wake_pending <= 1'b0;
    else if (wake_s && ctrl[rwsc_pkg::CTRL_WAKE_EN])
      wake_pending <= 1'b1;
    else if (wr_ok && adr_i == rwsc_pkg::OFS_CTRL && sel_i[0]
             && dat_i[rwsc_pkg::CTRL_WAKE_CLR])
      wake_pending <= 1'b0;
  end

  // Polarity and push-pull or open-drain drive; open drain only pulls
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_indicator_out <= 1'b0;
      wake_indicator_oe  <= 1'b0;
    end
    else
    begin
      wake_indicator_out <= wake_pending ^ !ctrl[rwsc_pkg::CTRL_WAKE_POL];
      wake_indicator_oe  <= !ctrl[rwsc_pkg::CTRL_WAKE_OD]
        || (wake_pending ^ !ctrl[rwsc_pkg::CTRL_WAKE_POL]) == 1'b0;
    end
  end

  // Sticky events, cleared by reading the interrupt register
  assign ev_set[rwsc_pkg::EV_WAKE]       = wake_s && ctrl[rwsc_pkg::CTRL_WAKE_EN];
  assign ev_set[rwsc_pkg::EV_WRITE_DROP] = wr_req && !wr_ok;
  assign ev_set[rwsc_pkg::EV_RESUME]     = mode == ST_SLEEP && wake_write;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ev_status <= '0;
    else if (sys_rst)
      ev_status <= '0;
    else if (rd_req && adr_i == rwsc_pkg::OFS_IRQ)
      ev_status <= ev_set;
    else
      ev_status <= ev_status | ev_set;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ev_mask <= '0;
    else if (sys_rst)
      ev_mask <= '0;
    else if (wr_ok && adr_i == rwsc_pkg::OFS_MASK && sel_i[0])
      ev_mask <= dat_i[rwsc_pkg::EV_W-1:0];
  end

  assign irq = |(ev_status & ev_mask);

  assign status_word = {25'h000_0000, wake_indicator_out, xover_latched,
                        speed_latched, link_full_duplex, speed_latched,
                        no_read, sleep_mode};

  // Read mux; unmapped reads return zero
  always_comb
  begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      rwsc_pkg::OFS_CTRL:      next_dat = {27'h000_0000, ctrl};
      rwsc_pkg::OFS_STATUS:    next_dat = status_word;
      rwsc_pkg::OFS_IRQ:       next_dat = {29'h0000_0000, ev_status};
      rwsc_pkg::OFS_MASK:      next_dat = {29'h0000_0000, ev_mask};
      rwsc_pkg::OFS_BYTE_TEST: next_dat = rwsc_pkg::BYTE_TEST_VAL;
      default:                 next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (rd_req)
        dat_o <= next_dat;
    end
  end
endmodule : reset_wake_strap_control
`default_nettype wire

// ### verilog/rwsc_pkg.sv
/*
  Constants for the reset, wake and strap control block.
  Assumes a single 20 MHz clock and a classic Wishbone register port.
*/
// Operation
// - External low reset resets control, mask, event and mode state, not the synchronisers or strap latches.
// - An internal power-on reset initialises the block without external reset.
// - Host writes are ignored until one read after power-up, reset or wake.
// - Enabled wake events drive the wake output; polarity and drive programmable.
// - Wake events and the wake output never leave the reduced-power state.
// - Chip select with write strobe together, or any bus write, leaves power-save, any data.
// - Crossover detection follows the crossover strap; low or open disables.
// - Speed strap is caught at reset release and held for link defaults.
// - Strap 0 gives 10M half no negotiation; 1 gives 100M half negotiation.
`default_nettype none
package rwsc_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_BYTE_TEST = 8'h10;
  // Control fields
  localparam int CTRL_WAKE_EN  = 0;
  localparam int CTRL_WAKE_POL = 1;
  localparam int CTRL_WAKE_OD  = 2;
  localparam int CTRL_SLEEP    = 3;
  localparam int CTRL_WAKE_CLR = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int ST_SLEEP    = 0;
  localparam int ST_NO_READ  = 1;
  localparam int ST_SPEED    = 2;
  localparam int ST_DUPLEX   = 3;
  localparam int ST_ANEG     = 4;
  localparam int ST_XOVER    = 5;
  localparam int ST_WAKE_OUT = 6;
  // Interrupt event bits
  localparam int EV_WAKE    = 0;
  localparam int EV_WRITE_DROP = 1;
  localparam int EV_RESUME  = 2;
  localparam int EV_W       = 3;
  // Byte-order test pattern, read-only
  localparam logic [31:0] BYTE_TEST_VAL = 32'h8765_4321;
  // Power-on reset stretch
  localparam int POR_NS     = 1000;
  localparam int CLK_NS     = 50;
  localparam int POR_CYCLES = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
endpackage : rwsc_pkg
`default_nettype wire

// ### verilog/rwsc_sync.sv
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clock.
*/
`default_nettype none
module rwsc_sync
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Level
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rwsc_sync
`default_nettype wire

// ### verif/rwsc_monitor.sv
/*
  Port checker for the reset, wake and strap control block.
  Assumes it is bound to every instance of that block.
*/
`default_nettype none
module rwsc_monitor
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire logic external_reset_low_input,
  input wire logic chip_select_low,
  input wire logic write_strobe_low,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic core_reset_n,
  input wire logic sleep_mode,
  input wire logic link_speed_100,
  input wire logic link_autoneg_en,
  input wire logic link_full_duplex,
  input wire logic crossover_auto_en,
  input wire logic wake_indicator_out,
  input wire logic wake_indicator_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Cycles since the last write cycle seen on pins or bus
  logic [3:0] since_wr;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      since_wr <= 4'hf;
    else if ((!chip_select_low && !write_strobe_low) || (cyc_i && we_i))
      since_wr <= 4'h0;
    else if (since_wr != 4'hf)
      since_wr <= since_wr + 4'h1;
  sequence s_req;
    cyc_i && stb_i && !ack_o && core_reset_n;
  endsequence
  sequence s_pin_reset;
    (!external_reset_low_input) [*3];
  endsequence
  property p_ack_next; s_req |=> ack_o; endproperty
  property p_ack_one; ack_o |=> !ack_o; endproperty
  property p_dup; core_reset_n |-> !link_full_duplex; endproperty
  property p_aneg; link_autoneg_en == link_speed_100; endproperty
  // Straps land one edge after core reset lifts, so look two edges back
  property p_spd_hold;
    $past(core_reset_n, 2) && core_reset_n |-> $stable(link_speed_100);
  endproperty
  property p_xo_hold;
    $past(core_reset_n, 2) && core_reset_n |-> $stable(crossover_auto_en);
  endproperty
  property p_oe; core_reset_n && !wake_indicator_oe |-> wake_indicator_out;
  endproperty
  property p_ext_rst; s_pin_reset |-> ##[0:2] !core_reset_n; endproperty
  property p_sync;
    $fell(external_reset_low_input) && core_reset_n |=> core_reset_n;
  endproperty
  property p_wake_src;
    $fell(sleep_mode) && $past(core_reset_n) && core_reset_n |-> since_wr < 4'h8;
  endproperty
  // irq and sleep_mode clear on the edge after core reset falls
  property p_rst_out; !core_reset_n |=> !irq && !sleep_mode; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  a_dup: assert property (p_dup) else $error("full duplex");
  a_aneg: assert property (p_aneg) else $error("aneg");
  a_spd_hold: assert property (p_spd_hold) else $error("speed");
  a_xo_hold: assert property (p_xo_hold) else $error("xover");
  a_oe: assert property (p_oe) else $error("wake drive");
  a_ext_rst: assert property (p_ext_rst) else $error("pin rst");
  a_sync: assert property (p_sync) else $error("unsynced");
  a_wake_src: assert property (p_wake_src) else $error("woke");
  a_rst_out: assert property (p_rst_out) else $error("rst out");
endmodule : rwsc_monitor
bind reset_wake_strap_control rwsc_monitor i_rwsc_monitor
(
  .clock(clock), .rst_n(rst_n), .irq(irq), .ack_o(ack_o),
  .external_reset_low_input(external_reset_low_input),
  .chip_select_low(chip_select_low), .write_strobe_low(write_strobe_low),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .core_reset_n(core_reset_n),
  .sleep_mode(sleep_mode), .link_speed_100(link_speed_100),
  .link_autoneg_en(link_autoneg_en), .link_full_duplex(link_full_duplex),
  .crossover_auto_en(crossover_auto_en),
  .wake_indicator_out(wake_indicator_out),
  .wake_indicator_oe(wake_indicator_oe)
);
`default_nettype wire

// ### verif/rwsc_host_pins.sv
/*
  Host pin model: wake write strobes and a wake event source.
  Assumes requests are single-cycle pulses from the bench.
*/
`default_nettype none
module rwsc_host_pins
(
  // Clock
  input  wire logic clock,
  // Requests
  input  wire logic wake_req,
  input  wire logic event_req,
  // Pins
  output logic      chip_select_low,
  output logic      write_strobe_low,
  output logic      wake_event
);
  timeunit 1ns;
  timeprecision 1ns;
  int pin_cnt = 0;
  int ev_cnt  = 0;
  // Held four cycles so both levels clear the input synchronisers
  always @(posedge clock)
  begin
    pin_cnt <= wake_req ? 4 : (pin_cnt > 0 ? pin_cnt - 1 : 0);
    ev_cnt  <= event_req ? 4 : (ev_cnt > 0 ? ev_cnt - 1 : 0);
  end
  assign chip_select_low  = !(pin_cnt > 0);
  assign write_strobe_low = !(pin_cnt > 0);
  assign wake_event       = ev_cnt > 0;
endmodule : rwsc_host_pins
`default_nettype wire

// ### verif/testbench.sv
/*
  Self-checking bench for the reset, wake and strap control block.
  Assumes a 20 MHz clock and the host pin model.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst_n = 1'b0, ext_rst_n = 1'b1;
  logic        xover = 1'b0, speed = 1'b0, wake_req = 1'b0, event_req = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  wire logic   cs_n, wr_n, wev, wout, woe, spd, fdx, aneg, xen, slp, core_n;
  wire logic   ack, irq;
  wire logic [31:0] rdat;
  int          fails = 0, checks_done = 0, n;
  bit          m_no_read, m_sleep;
  logic [31:0] m_ctrl;
  initial forever #25 clock = !clock;
  reset_wake_strap_control i_reset_wake_strap_control (.clock(clock),
    .rst_n(rst_n), .external_reset_low_input(ext_rst_n),
    .chip_select_low(cs_n), .write_strobe_low(wr_n), .wake_event(wev),
    .crossover_auto_strap(xover), .speed_strap(speed),
    .wake_indicator_out(wout), .wake_indicator_oe(woe), .link_speed_100(spd),
    .link_full_duplex(fdx), .link_autoneg_en(aneg), .crossover_auto_en(xen),
    .sleep_mode(slp), .core_reset_n(core_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .irq(irq));
  rwsc_host_pins i_rwsc_host_pins (.clock(clock), .wake_req(wake_req),
    .event_req(event_req), .chip_select_low(cs_n), .write_strobe_low(wr_n),
    .wake_event(wev));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do @(posedge clock); while (ack !== 1'b1 && ++n < 50);
    q = rdat;
    if (n >= 50) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    if (m_sleep)
      {m_sleep, m_no_read} = 2'b01;
    else if (a == rwsc_pkg::OFS_CTRL && !m_no_read && !m_sleep)
      {m_sleep, m_ctrl} = {d[3], 29'h0, d[2:0]};
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
    m_no_read = 0;
  endtask : rd
  task automatic wait_core;
    n = 0;
    while (core_n !== 1'b1 && n < 200) @(posedge clock) n++;
    repeat (3) @(posedge clock);
    {m_sleep, m_no_read, m_ctrl} = {2'b01, 32'h0000_0000};
  endtask : wait_core
  task automatic links;
    check("speed", 32'(spd), 32'(speed));
    check("aneg", 32'(aneg), 32'(speed));
    check("duplex", 32'(fdx), 32'h0000_0000);
    check("xover", 32'(xen), 32'(xover));
  endtask : links
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'hb8a38487));
    speed = $urandom_range(1);
    xover = $urandom_range(1);
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    wait_core();
    links();
    $display("test straps done");
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_0003);
    rd("irq", rwsc_pkg::OFS_IRQ, 32'h0000_0002);
    rd("ctrl", rwsc_pkg::OFS_CTRL, m_ctrl);
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_0003);
    rd("ctrl", rwsc_pkg::OFS_CTRL, m_ctrl);
    rd("stat", rwsc_pkg::OFS_STATUS,
       {26'h0, xover, speed, 1'b0, speed, 2'b00});
    rd("unmapped", 8'h20, 32'h0000_0000);
    rd("bytes", rwsc_pkg::OFS_BYTE_TEST, rwsc_pkg::BYTE_TEST_VAL);
    $display("test first read done");
    wr(rwsc_pkg::OFS_MASK, 32'h0000_0001);
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_000b);
    event_req <= 1'b1;
    @(posedge clock) event_req <= 1'b0;
    repeat (8) @(posedge clock);
    check("wake out", 32'(wout), 32'h0000_0001);
    check("irq pin", 32'(irq), 32'h0000_0001);
    check("still asleep", 32'(slp), 32'(m_sleep));
    wr(rwsc_pkg::OFS_BYTE_TEST, $urandom);
    check("bus wake", 32'(slp), 32'(m_sleep));
    rd("irq wake", rwsc_pkg::OFS_IRQ, 32'h0000_0007);
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_001b);
    wake_req <= 1'b1;
    @(posedge clock) wake_req <= 1'b0;
    repeat (10) @(posedge clock);
    {m_sleep, m_no_read} = 2'b01;
    check("pin wake", 32'(slp), 32'h0000_0000);
    check("wake clr", 32'(wout), 32'h0000_0000);
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_0000);
    rd("ctrl wake", rwsc_pkg::OFS_CTRL, m_ctrl);
    $display("test wake done");
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_0007);
    check("od low", 32'(woe), 32'h0000_0001);
    wr(rwsc_pkg::OFS_CTRL, 32'h0000_0005);
    check("od high", 32'(woe), 32'h0000_0000);
    $display("test drive done");
    ext_rst_n <= 1'b0;
    speed <= !speed;
    xover <= !xover;
    repeat (4) @(posedge clock);
    ext_rst_n <= 1'b1;
    wait_core();
    links();
    rd("irq rst", rwsc_pkg::OFS_IRQ, 32'h0000_0000);
    rd("ctrl rst", rwsc_pkg::OFS_CTRL, m_ctrl);
    $display("test pin reset done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
